/* File: onoff_defs.svh */
`ifndef ONOFF_DEFS_SVH
`define ONOFF_DEFS_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_MHZ         40
`define DEB_SHORT_US    100
`define DEB_SHORT_CYC   (`DEB_SHORT_US * `CLK_MHZ)
`define DEB_LONG_MS     30
`define DEB_LONG_CYC    (`DEB_LONG_MS * 1000 * `CLK_MHZ)
`define MANUAL_RESET_FLAG_SHORT_S    8
`define MANUAL_RESET_FLAG_SHORT_CYC  (`MANUAL_RESET_FLAG_SHORT_S * 1000000 * `CLK_MHZ)
`define MANUAL_RESET_FLAG_LONG_S     16
`define MANUAL_RESET_FLAG_LONG_CYC   (`MANUAL_RESET_FLAG_LONG_S * 1000000 * `CLK_MHZ)
`define SLOT_LAST       4'h7

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CFG_A       6'h00
`define OFS_CFG_B       6'h04
`define OFS_INT_MASK    6'h08
`define OFS_INT_FLAG    6'h0c
`define OFS_ERC         6'h10
`define OFS_STATUS      6'h14

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define CFGA_W          5
`define CFGA_RST        5'h00
`define MASK_RST        2'h3
`define SYNC_RST        5'h11
`define MODE_PUSH       2'h0
`define MODE_SLIDE      2'h1
`define MODE_LOGIC      2'h2
`define CMD_SOFT_OFF    3'h1
`define CMD_STANDBY     3'h3
`define CMD_EXIT_STBY   3'h4
`define INT_FALL        0
`define INT_RISE        1
`define ERC_MANUAL_RESET_FLAG        0

`endif

/* File: onoff_pkg.sv */
package onoff_pkg;

    typedef enum logic [2:0] {
        ST_SHDN, ST_WAKE, ST_PWRUP, ST_ON, ST_PWRDN, ST_STBY
    } state_e;

    typedef struct packed {
        logic       manual_reset_flag_long;
        logic       pullup_disable;
        logic [1:0] key_input_mode;
        logic       key_debounce_select;
    } cfg_a_s;

    typedef struct packed {
        logic       vld;
        logic [2:0] code;
    } cmd_s;

endpackage

/* File: key_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
`include "onoff_defs.svh"

module key_debounce #(
    parameter int unsigned LONG_CYC = `DEB_LONG_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_raw,
    input  wire logic i_long,
    output var  logic o_deb
);
    localparam logic [20:0] SHORT_LIM = 21'(`DEB_SHORT_CYC - 1);
    localparam logic [20:0] LONG_LIM  = 21'(LONG_CYC - 1);

    logic [20:0] cnt_r;
    logic [20:0] limit;

    assign limit = i_long ? LONG_LIM : SHORT_LIM;

    // any return to the output level restarts the count, so bounces on
    // either edge are rejected
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_r <= 21'h0;
            o_deb <= 1'b1;
        end else if (i_raw == o_deb) begin
            cnt_r <= 21'h0;
        end else if (cnt_r == limit) begin
            cnt_r <= 21'h0;
            o_deb <= i_raw; // R11
        end else begin
            cnt_r <= cnt_r + 21'h1;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_deb_full;
        !$stable(o_deb) |-> $past(cnt_r) == $past(limit) && $past(i_raw) == o_deb;
    endproperty
    a_deb_full: assert property (p_deb_full) // R11
        else $error("debounce output changed before full period");

endmodule
`default_nettype wire

/* File: hold_timer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "onoff_defs.svh"

module hold_timer #(
    parameter int unsigned SHORT_CYC = `MANUAL_RESET_FLAG_SHORT_CYC,
    parameter int unsigned LONG_CYC  = `MANUAL_RESET_FLAG_LONG_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_active,
    input  wire logic i_long,
    output var  logic o_done
);
    localparam logic [29:0] SHORT_LIM = 30'(SHORT_CYC - 1);
    localparam logic [29:0] LONG_LIM  = 30'(LONG_CYC - 1);

    logic [29:0] cnt_r;
    logic [29:0] limit;

    assign limit  = i_long ? LONG_LIM : SHORT_LIM; // R23
    // compare with >= so a switch to the shorter time mid-count still ends
    assign o_done = i_active && cnt_r >= limit;

    always_ff @(posedge i_clk) begin
        if (!i_rstn || !i_active) begin
            cnt_r <= 30'h0; // R26
        end else if (cnt_r < limit) begin
            cnt_r <= cnt_r + 30'h1;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    property p_restart;
        !i_active |=> cnt_r == 30'h0;
    endproperty
    a_restart: assert property (p_restart) // R26
        else $error("hold timer not restarted");

endmodule
`default_nettype wire

/* File: onkey_onoff_controller.sv */
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "onoff_defs.svh"

// How it works
// (R1) on-key is active low, debounced, duration chosen by debounce select
// (R2) mode field: 0 push-button, 1 slide-switch, 2 logic level
// (R3) push-button and slide-switch: debounced falling edge starts power-up
// (R4) logic mode: low level powers up, high level powers down
// (R5) logic mode skips the debounce filter and uses the raw level
// (R6) manual reset is looked at only in Resource On
// (R7) push-button held low for hold time: power down to Shutdown
// (R8) slide-switch held high for hold time: power down to Shutdown
// (R9) logic mode: no hold timer, high level powers down at once
// (R10) every key manual reset sets the manual reset flag
// (R11) debounce acts on both edges, needs a full stable period
// (R12) pull-up on when disable bit is 0, off when 1
// (R13) separate rise and fall key interrupts, each with own mask bit
// (R14) open-drain interrupt pin low while any unmasked flag pends
// (R15) host firmware unmasks the interrupts it needs
// (R16) wake from Shutdown passes wake, fault check, power-up to On
// (R17) manual reset in On powers down back to Shutdown
// (R18) host turns off by soft-off command or by key high
// (R19) command 3 powers slots down into Standby, bias stays alive
// (R20) command 4 in Standby goes back through wake to On
// (R21) subordinate systems should choose logic mode in configuration
// (R22) debounce select picks 100 us or 30 ms
// (R23) manual reset hold time selectable 8 s or 16 s
// (R24) wake on debounced fall, logic low, or cold-reset wake flag
// (R25) wake proceeds only with undervoltage, overvoltage, thermal clear
// (R26) hold timer restarts when key leaves the asserting level
module onkey_onoff_controller
    import onoff_pkg::*;
#(
    parameter int unsigned DEB_LONG_CYC   = `DEB_LONG_CYC,
    parameter int unsigned MANUAL_RESET_FLAG_SHORT_CYC = `MANUAL_RESET_FLAG_SHORT_CYC,
    parameter int unsigned MANUAL_RESET_FLAG_LONG_CYC  = `MANUAL_RESET_FLAG_LONG_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output var  logic [31:0] o_wb_dat,
    output var  logic        o_wb_ack,
    input  wire logic        i_on_key_n,
    input  wire logic        i_undervoltage,
    input  wire logic        i_overvoltage,
    input  wire logic        i_thermal_overload,
    input  wire logic        i_cold_wake,
    input  wire logic        i_irq_out_n,
    output var  logic        o_irq_out_n,
    output var  logic        o_irq_out_n_oe,
    output var  logic        o_pullup_en,
    output var  logic        o_bias_en,
    output var  logic [3:0]  o_slot_en
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] async_in;
    logic [4:0] sync1_r;
    logic [4:0] sync2_r;
    logic       key_s;
    logic [2:0] fault_s;
    logic       irq_pin_s;

    assign async_in = {i_irq_out_n, i_thermal_overload, i_overvoltage,
                       i_undervoltage, i_on_key_n};

    // key and interrupt wire reset to their released (high) level
    localparam logic [4:0] SYNC_INIT = `SYNC_RST;

    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_sync
            always_ff @(posedge i_clk) begin
                if (!i_rstn) begin
                    sync1_r[g] <= SYNC_INIT[g];
                    sync2_r[g] <= SYNC_INIT[g];
                end else begin
                    sync1_r[g] <= async_in[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    assign key_s     = sync2_r[0];
    assign fault_s   = sync2_r[3:1];
    assign irq_pin_s = sync2_r[4];

    // ------------------------------------------------------------------
    // registers and bus state
    // ------------------------------------------------------------------
    cfg_a_s     cfg_a_r;
    cmd_s       cmd_r;
    logic [1:0] int_mask_r;
    logic [1:0] int_flag_r;
    logic [3:0] erc_r;
    state_e     state_r;
    state_e     target_r;
    logic [3:0] tick_r;

    logic       wr_acc;
    logic       rd_byte0;
    logic [5:0] ofs;
    logic [31:0] rd_val;

    assign ofs      = {i_wb_adr[5:2], 2'b00};
    assign wr_acc   = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
    assign rd_byte0 = wr_acc && i_wb_sel[0];

    // ------------------------------------------------------------------
    // key path
    // ------------------------------------------------------------------
    logic is_logic;
    logic is_push;
    logic is_slide;
    logic key_deb;
    logic key_eff;
    logic key_eff_d_r;
    logic key_fell;
    logic key_rose;
    logic manual_reset_flag_active;
    logic manual_reset_flag_done;
    logic manual_reset_flag_req;
    logic wake_req;
    logic faults;

    assign is_push  = cfg_a_r.key_input_mode == `MODE_PUSH;  // R2
    assign is_slide = cfg_a_r.key_input_mode == `MODE_SLIDE; // R2
    assign is_logic = cfg_a_r.key_input_mode == `MODE_LOGIC; // R2

    key_debounce #(
        .LONG_CYC (DEB_LONG_CYC)
    ) u_deb (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_raw  (key_s),
        .i_long (cfg_a_r.key_debounce_select), // R1 R22
        .o_deb  (key_deb)
    );

    // logic mode trades glitch rejection for zero delay
    assign key_eff  = is_logic ? key_s : key_deb; // R5
    assign key_fell = key_eff_d_r && !key_eff;
    assign key_rose = !key_eff_d_r && key_eff;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            key_eff_d_r <= 1'b1;
        end else begin
            key_eff_d_r <= key_eff;
        end
    end

    // timer runs only in Resource On, at the mode's asserting level
    assign manual_reset_flag_active = state_r == ST_ON &&
                         ((is_push && !key_deb) ||
                          (is_slide && key_deb)); // R6 R7 R8

    hold_timer #(
        .SHORT_CYC (MANUAL_RESET_FLAG_SHORT_CYC),
        .LONG_CYC  (MANUAL_RESET_FLAG_LONG_CYC)
    ) u_manual_reset_flag (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_active (manual_reset_flag_active),
        .i_long   (cfg_a_r.manual_reset_flag_long),
        .o_done   (manual_reset_flag_done)
    );

    assign manual_reset_flag_req = state_r == ST_ON &&
                      (manual_reset_flag_done || (is_logic && key_s)); // R9 R18
    assign wake_req = (!is_logic && key_fell) ||
                      (is_logic && !key_s) || i_cold_wake; // R3 R4 R24
    assign faults   = |erc_r[3:1];

    // ------------------------------------------------------------------
    // on/off controller
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            state_r   <= ST_SHDN;
            target_r  <= ST_SHDN;
            tick_r    <= 4'h0;
            o_slot_en <= 4'h0;
        end else begin
            tick_r <= (tick_r == `SLOT_LAST) ? 4'h0 : tick_r + 4'h1;
            case (state_r)
                ST_SHDN: begin
                    if (wake_req) begin
                        state_r <= ST_WAKE; // R16
                    end
                end
                ST_WAKE: begin
                    tick_r <= 4'h0;
                    state_r <= faults ? ST_SHDN : ST_PWRUP; // R25
                end
                ST_PWRUP: begin
                    if (tick_r == `SLOT_LAST) begin
                        o_slot_en <= {o_slot_en[2:0], 1'b1};
                        if (o_slot_en[2]) begin
                            state_r <= ST_ON; // R16
                        end
                    end
                end
                ST_ON: begin
                    tick_r <= 4'h0;
                    if (manual_reset_flag_req || (cmd_r.vld &&
                                     cmd_r.code == `CMD_SOFT_OFF)) begin
                        state_r  <= ST_PWRDN; // R17 R18
                        target_r <= ST_SHDN;
                    end else if (cmd_r.vld &&
                                 cmd_r.code == `CMD_STANDBY) begin
                        state_r  <= ST_PWRDN; // R19
                        target_r <= ST_STBY;
                    end
                end
                ST_PWRDN: begin
                    if (tick_r == `SLOT_LAST) begin
                        o_slot_en <= {1'b0, o_slot_en[3:1]};
                        if (!o_slot_en[1]) begin
                            state_r <= target_r;
                        end
                    end
                end
                ST_STBY: begin
                    if (cmd_r.vld && cmd_r.code == `CMD_EXIT_STBY) begin
                        state_r <= ST_WAKE; // R20
                    end
                end
                default: begin
                    state_r <= ST_SHDN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // flags: a set in the same cycle as a clear wins
    // ------------------------------------------------------------------
    logic [1:0] int_set;
    logic [3:0] erc_set;

    assign int_set = {key_rose, key_fell}; // R13
    assign erc_set = {fault_s, manual_reset_flag_req};  // R10

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            int_flag_r <= 2'h0;
        end else begin
            int_flag_r <= (int_flag_r & ~((rd_byte0 &&
                          ofs == `OFS_INT_FLAG) ? i_wb_dat[1:0] : 2'h0))
                          | int_set;
        end
    end

    // cleared only by software or by i_rstn; shutdown keeps it for the next boot
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            erc_r <= 4'h0;
        end else begin
            erc_r <= (erc_r & ~((rd_byte0 && ofs == `OFS_ERC) ?
                      i_wb_dat[3:0] : 4'h0)) | erc_set;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_irq_out_n    <= 1'b0;
            o_irq_out_n_oe <= 1'b0;
            // pull-up disable resets to 0, so the pull-up is on in reset
            o_pullup_en    <= 1'b1;
            o_bias_en      <= 1'b0;
        end else begin
            o_irq_out_n    <= 1'b0;
            o_irq_out_n_oe <= |(int_flag_r & ~int_mask_r); // R14
            o_pullup_en    <= !cfg_a_r.pullup_disable;      // R12
            o_bias_en      <= state_r != ST_SHDN;
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave: ack one cycle after the strobe, then a gap
    // ------------------------------------------------------------------
    always_comb begin
        rd_val = 32'h0000_0000;
        case (ofs)
            `OFS_CFG_A:    rd_val[4:0] = cfg_a_r;
            `OFS_INT_MASK: rd_val[1:0] = int_mask_r;
            `OFS_INT_FLAG: rd_val[1:0] = int_flag_r;
            `OFS_ERC:      rd_val[3:0] = erc_r;
            `OFS_STATUS:   rd_val[5:0] = {irq_pin_s, key_s, key_deb,
                                          state_r};
            default:       rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
            o_wb_dat <= rd_val;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cfg_a_r    <= `CFGA_RST;
            int_mask_r <= `MASK_RST; // R15
            cmd_r      <= '0;
        end else begin
            cmd_r.vld <= 1'b0;
            if (rd_byte0 && ofs == `OFS_CFG_A) begin
                cfg_a_r <= i_wb_dat[`CFGA_W-1:0];
            end
            if (rd_byte0 && ofs == `OFS_INT_MASK) begin
                int_mask_r <= i_wb_dat[1:0]; // R13
            end
            if (rd_byte0 && ofs == `OFS_CFG_B) begin
                cmd_r.vld  <= 1'b1;
                cmd_r.code <= i_wb_dat[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_wake_ok;
        state_r == ST_WAKE && !faults;
    endsequence

    property p_push_wake;
        state_r == ST_SHDN && !is_logic && key_fell |=> state_r == ST_WAKE;
    endproperty
    a_push_wake: assert property (p_push_wake) // R3
        else $error("falling key edge did not wake");

    property p_logic_off;
        state_r == ST_ON && is_logic && key_s
            |=> state_r == ST_PWRDN && erc_r[`ERC_MANUAL_RESET_FLAG];
    endproperty
    a_logic_off: assert property (p_logic_off) // R9
        else $error("logic high did not power down with flag");

    property p_faults;
        state_r == ST_WAKE && faults |=> state_r == ST_SHDN;
    endproperty
    a_faults: assert property (p_faults) // R25
        else $error("wake proceeded with fault flags");

    property p_wake_up;
        s_wake_ok |=> state_r == ST_PWRUP ##[1:40] state_r == ST_ON;
    endproperty
    a_wake_up: assert property (p_wake_up) // R16
        else $error("power-up did not reach resource on");

    property p_irq;
        |(int_flag_r & ~int_mask_r) |=> o_irq_out_n_oe;
    endproperty
    a_irq: assert property (p_irq) // R14
        else $error("unmasked flag did not drive interrupt");

    property p_fall_flag;
        key_fell |=> int_flag_r[`INT_FALL];
    endproperty
    a_fall_flag: assert property (p_fall_flag) // R13
        else $error("falling key edge lost");

    property p_standby;
        state_r == ST_ON && !manual_reset_flag_req && cmd_r.vld &&
        cmd_r.code == `CMD_STANDBY
            |=> state_r == ST_PWRDN && target_r == ST_STBY;
    endproperty
    a_standby: assert property (p_standby) // R19
        else $error("standby command ignored");

    property p_exit;
        state_r == ST_STBY && cmd_r.vld && cmd_r.code == `CMD_EXIT_STBY
            |=> state_r == ST_WAKE;
    endproperty
    a_exit: assert property (p_exit) // R20
        else $error("standby exit ignored");

    property p_pullup;
        ##1 o_pullup_en == !$past(cfg_a_r.pullup_disable);
    endproperty
    a_pullup: assert property (p_pullup) // R12
        else $error("pull-up enable wrong");

endmodule
`default_nettype wire

/* File: key_host.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// on-key switch and host side of the interrupt wire
// ----------------------------------------------------------------------
module key_host (
    input  wire logic i_clk,
    input  wire logic i_press,
    input  wire logic i_drive_hi,
    input  wire logic i_pullup_en,
    input  wire logic i_irq_n,
    input  wire logic i_irq_oe,
    output var  logic o_key_n,
    output var  logic o_irq_n
);
    logic float_r = 1'b0;

    // a floating pin wanders, so it never settles into a clean level
    always_ff @(posedge i_clk) begin
        float_r <= ~float_r;
    end

    always_comb begin
        if (i_press)
            o_key_n = 1'b0;
        else if (i_drive_hi | i_pullup_en)
            o_key_n = 1'b1;
        else
            o_key_n = float_r;
        // host pull-up holds the wire high unless the device sinks it
        o_irq_n = i_irq_oe ? i_irq_n : 1'b1;
    end
endmodule

`default_nettype wire

/* File: test_onkey_onoff_controller.sv */
`timescale 1ns/1ps
`default_nettype none
`include "onoff_defs.svh"

module test_onkey_onoff_controller
    import onoff_pkg::*;
();
    logic        clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0;
    logic        we = 1'b0, press = 1'b0, drive_hi = 1'b0, cold = 1'b0;
    logic        uv = 1'b0, ov = 1'b0, tov = 1'b0;
    logic [7:0]  adr = 8'h0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [3:0]  slots;
    logic        ack, irq_n, irq_oe, pu_en, bias, key_n, irq_wire;
    int          num_errors = 0, tests_run = 0, seed = 58;

    onkey_onoff_controller #(.DEB_LONG_CYC(50), .MANUAL_RESET_FLAG_SHORT_CYC(100),
        .MANUAL_RESET_FLAG_LONG_CYC(200)) u_dut (
        .i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_on_key_n(key_n),
        .i_undervoltage(uv), .i_overvoltage(ov),
        .i_thermal_overload(tov), .i_cold_wake(cold),
        .i_irq_out_n(irq_wire), .o_irq_out_n(irq_n),
        .o_irq_out_n_oe(irq_oe), .o_pullup_en(pu_en), .o_bias_en(bias),
        .o_slot_en(slots));

    key_host u_host (.i_clk(clk), .i_press(press), .i_drive_hi(drive_hi),
        .i_pullup_en(pu_en), .i_irq_n(irq_n), .i_irq_oe(irq_oe),
        .o_key_n(key_n), .o_irq_n(irq_wire));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // bus, check and expectation helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [5:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {2'h0, a};
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        chk({31'h0, ack}, 32'h1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    // polls the state field; a bounded count stands in for a hang
    task automatic wait_st(input state_e s, input int lim);
        int n;
        n = 0;
        do begin
            wb(1'b0, `OFS_STATUS, 32'h0);
            n++;
        end while (q[2:0] !== s && n < lim);
        chk({29'h0, q[2:0]}, {29'h0, s});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [31:0] cfg_w(input logic [1:0] m,
        input logic d, input logic p, input logic l);
        cfg_a_s c;
        c.manual_reset_flag_long = l;
        c.pullup_disable = p;
        c.key_input_mode = m;
        c.key_debounce_select = d;
        return {27'h0, c};
    endfunction

    function automatic logic [31:0] slot_exp(input state_e s);
        return (s == ST_ON) ? 32'hf : 32'h0;
    endfunction

    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        tick(40000);
        num_errors++;
        wrap_up;
    end

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        tick(20);
        rstn <= 1'b1;
        tick(1);
        rd(`OFS_CFG_A, 32'h0);
        rd(`OFS_INT_MASK, {30'h0, `MASK_RST});
        rd(6'h3c, 32'h0);
        chk({31'h0, pu_en}, 32'h1);
        wb(1'b1, `OFS_CFG_A, cfg_w(`MODE_PUSH, 1'b1, 1'b0, 1'b0));
        for (int i = 0; i < 3; i++) begin
            press <= 1'b1;
            tick(1 + $unsigned($random(seed)) % 40);
            press <= 1'b0;
            tick(60);
        end
        wait_st(ST_SHDN, 1);
        press <= 1'b1;
        wait_st(ST_ON, 60);
        chk({28'h0, slots}, slot_exp(ST_ON));
        press <= 1'b0;
        tick(60);
        repeat (2) begin
            press <= 1'b1;
            tick(80);
            press <= 1'b0;
            tick(60);
        end
        wait_st(ST_ON, 1);
        press <= 1'b1;
        wait_st(ST_SHDN, 100);
        rd(`OFS_ERC, 32'h1);
        press <= 1'b0;
        tick(60);
        wb(1'b1, `OFS_ERC, 32'hf);
        wb(1'b1, `OFS_CFG_A, cfg_w(`MODE_SLIDE, 1'b1, 1'b0, 1'b1));
        press <= 1'b1;
        wait_st(ST_ON, 60);
        press <= 1'b0;
        tick(150);
        wait_st(ST_ON, 1);
        wait_st(ST_SHDN, 80);
        rd(`OFS_ERC, 32'h1);
        wb(1'b1, `OFS_ERC, 32'hf);
        drive_hi <= 1'b1;
        wb(1'b1, `OFS_CFG_A, cfg_w(`MODE_LOGIC, 1'b1, 1'b1, 1'b0));
        chk({31'h0, pu_en}, 32'h0);
        wb(1'b1, `OFS_INT_MASK, 32'h1);
        wb(1'b1, `OFS_INT_FLAG, 32'h3);
        press <= 1'b1;
        tick(3);
        wb(1'b0, `OFS_STATUS, 32'h0);
        chk({31'h0, q[2:0] == ST_SHDN}, 32'h0);
        wait_st(ST_ON, 30);
        chk({31'h0, irq_oe}, 32'h0);
        rd(`OFS_INT_FLAG, 32'h1);
        wb(1'b1, `OFS_CFG_B, {29'h0, `CMD_STANDBY});
        wait_st(ST_STBY, 30);
        chk({31'h0, bias}, 32'h1);
        chk({28'h0, slots}, slot_exp(ST_STBY));
        wb(1'b1, `OFS_CFG_B, {29'h0, `CMD_EXIT_STBY});
        wait_st(ST_ON, 30);
        press <= 1'b0;
        wait_st(ST_SHDN, 30);
        rd(`OFS_ERC, 32'h1);
        chk({31'h0, irq_oe}, 32'h1);
        wb(1'b0, `OFS_STATUS, 32'h0);
        chk({31'h0, q[5]}, 32'h0);
        wb(1'b1, `OFS_INT_FLAG, 32'h3);
        tick(2);
        chk({31'h0, irq_oe}, 32'h0);
        tick(60);
        wb(1'b1, `OFS_ERC, 32'hf);
        wb(1'b1, `OFS_CFG_A, cfg_w(`MODE_PUSH, 1'b0, 1'b0, 1'b0));
        uv <= 1'b1;
        tick(4);
        cold <= 1'b1;
        tick(1);
        cold <= 1'b0;
        tick(20);
        wait_st(ST_SHDN, 1);
        rd(`OFS_ERC, 32'h2);
        uv <= 1'b0;
        tick(4);
        wb(1'b1, `OFS_ERC, 32'hf);
        cold <= 1'b1;
        tick(1);
        cold <= 1'b0;
        wait_st(ST_ON, 30);
        wb(1'b1, `OFS_CFG_B, {29'h0, `CMD_SOFT_OFF});
        wait_st(ST_SHDN, 30);
        rd(`OFS_ERC, 32'h0);
        chk({31'h0, bias}, 32'h0);
        press <= 1'b1;
        tick(3900);
        wb(1'b0, `OFS_STATUS, 32'h0);
        chk({31'h0, q[3]}, 32'h1);
        wait_st(ST_ON, 100);
        wrap_up;
    end
endmodule

`default_nettype wire
